/* File: usb_control_request_decoder.sv */
// Endpoint zero control request decoder: vendor register read,
// address assignment and configuration, with device state tracking.
// Assumes the serial engine and register file share sys_clk, so no
// input here needs a synchroniser; reg_rdata answers reg_addr at once.
//
// Contract
// - Vendor read is C0 01, value zero, index low address, length one.
// - The index low byte selects the internal register to read.
// - Data stage returns one byte: the addressed register's content.
// - Set address uses code 05, value low 00 to 7F; adopt it.
// - Set configuration is code 09, value low config, rest zero.
// - Configuration value 00 leaves or returns to unconfigured state.
// - Configuration value 01 enters the configured state.
`timescale 1ns/10ps
`include "usb_ctrl_map.svh"

module usb_control_request_decoder
   import usb_ctrl_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic setup_valid,
   input wire setup_t setup,
   input wire logic status_done,
   input wire logic [7:0] reg_rdata,
   output logic req_ack,
   output logic req_stall,
   output logic reg_rd,
   output logic [7:0] reg_addr,
   output logic in_valid,
   output logic [7:0] in_data,
   output logic [6:0] dev_addr,
   output dev_state_t dev_state
);

   ////////////////////////////////////////////////////////////////////////
   // Request decode.

   logic is_vendor;
   logic is_set_addr;
   logic is_set_cfg;

   always_comb begin
      is_vendor = (setup.req_type == `RT_VENDOR_IN) &&
                  (setup.request == `RQ_VENDOR_READ) &&
                  (setup.value_lo == `ZERO_BYTE) &&
                  (setup.value_hi == `ZERO_BYTE) &&
                  (setup.index_hi == `ZERO_BYTE) &&
                  (setup.length_lo == `VENDOR_LEN) &&
                  (setup.length_hi == `ZERO_BYTE);
      is_set_addr = (setup.req_type == `RT_STD_OUT) &&
                    (setup.request == `RQ_SET_ADDRESS) &&
                    (setup.value_lo <= `DEV_ADDR_MAX) &&
                    (setup.value_hi == `ZERO_BYTE) &&
                    (setup.index_lo == `ZERO_BYTE) &&
                    (setup.index_hi == `ZERO_BYTE) &&
                    (setup.length_lo == `ZERO_BYTE) &&
                    (setup.length_hi == `ZERO_BYTE);
      // Only values 00 and 01 exist; anything else is refused.
      is_set_cfg = (setup.req_type == `RT_STD_OUT) &&
                   (setup.request == `RQ_SET_CONFIG) &&
                   ((setup.value_lo == `CFG_NONE) ||
                    (setup.value_lo == `CFG_ONE)) &&
                   (setup.value_hi == `ZERO_BYTE) &&
                   (setup.index_lo == `ZERO_BYTE) &&
                   (setup.index_hi == `ZERO_BYTE) &&
                   (setup.length_lo == `ZERO_BYTE) &&
                   (setup.length_hi == `ZERO_BYTE);
   end

   ////////////////////////////////////////////////////////////////////////
   // Transfer and device state.

   ctl_state_t ctl;
   ctl_state_t next_ctl;
   dev_state_t next_dev_state;
   logic [6:0] pend_addr;
   logic [6:0] next_pend_addr;
   logic [6:0] next_dev_addr;
   logic next_req_ack;
   logic next_req_stall;
   logic next_reg_rd;
   logic [7:0] next_reg_addr;
   logic next_in_valid;
   logic [7:0] next_in_data;

   always_comb begin
      next_ctl = ctl;
      next_dev_state = dev_state;
      next_pend_addr = pend_addr;
      next_dev_addr = dev_addr;
      next_req_ack = 1'b0;
      next_req_stall = 1'b0;
      next_reg_rd = 1'b0;
      next_reg_addr = reg_addr;
      next_in_valid = 1'b0;
      next_in_data = in_data;
      // A fresh setup always wins: it abandons a read or a pending address.
      if (setup_valid) begin
         next_ctl = CT_IDLE;
         if (is_vendor) begin
            // Accepted whatever the device state; addresses above the
            // sensor range are passed on unchecked, as their result is
            // left open.
            next_req_ack = 1'b1;
            next_reg_rd = 1'b1;
            next_reg_addr = setup.index_lo;
            next_ctl = CT_READ;
         end else if (is_set_addr) begin
            next_req_ack = 1'b1;
            next_pend_addr = setup.value_lo[6:0];
            next_ctl = CT_ADDR;
         end else if (is_set_cfg) begin
            next_req_ack = 1'b1;
            // In the default state the outcome is undefined, so the
            // request is acknowledged and the state is left alone.
            if (dev_state != DEV_DEFAULT) begin
               if (setup.value_lo == `CFG_ONE) begin
                  next_dev_state = DEV_CONFIGURED;
               end else begin
                  next_dev_state = DEV_ADDRESSED;
               end
            end
         end else begin
            next_req_stall = 1'b1;
         end
      end else begin
         unique case (ctl)
            CT_IDLE: begin
               next_ctl = CT_IDLE;
            end
            CT_READ: begin
               next_in_data = reg_rdata;
               next_in_valid = 1'b1;
               next_ctl = CT_IDLE;
            end
            CT_ADDR: begin
               // The old address must answer the status stage itself.
               if (status_done) begin
                  next_dev_addr = pend_addr;
                  if (pend_addr == `DEV_ADDR_RST) begin
                     next_dev_state = DEV_DEFAULT;
                  end else if (dev_state == DEV_DEFAULT) begin
                     next_dev_state = DEV_ADDRESSED;
                  end
                  next_ctl = CT_IDLE;
               end
            end
            default: begin
               next_ctl = CT_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         ctl <= CT_IDLE;
         dev_state <= DEV_DEFAULT;
         pend_addr <= `DEV_ADDR_RST;
         dev_addr <= `DEV_ADDR_RST;
         req_ack <= 1'b0;
         req_stall <= 1'b0;
         reg_rd <= 1'b0;
         reg_addr <= `DATA_RST;
         in_valid <= 1'b0;
         in_data <= `DATA_RST;
      end else begin
         ctl <= next_ctl;
         dev_state <= next_dev_state;
         pend_addr <= next_pend_addr;
         dev_addr <= next_dev_addr;
         req_ack <= next_req_ack;
         req_stall <= next_req_stall;
         reg_rd <= next_reg_rd;
         reg_addr <= next_reg_addr;
         in_valid <= next_in_valid;
         in_data <= next_in_data;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks.

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rstn);

   property p_vendor_ack;
      setup_valid && is_vendor |=> req_ack && reg_rd && !req_stall;
   endproperty
   a_vendor_ack: assert property (p_vendor_ack)
      else $error("vendor read not acknowledged");

   property p_reg_addr;
      setup_valid && is_vendor |=> reg_addr == $past(setup.index_lo);
   endproperty
   a_reg_addr: assert property (p_reg_addr)
      else $error("register address not taken from index low");

   property p_read_data;
      reg_rd && !setup_valid |=> in_valid && in_data == $past(reg_rdata);
   endproperty
   a_read_data: assert property (p_read_data)
      else $error("read data byte wrong or missing");

   property p_addr_wait;
      ctl == CT_ADDR && !status_done |=> dev_addr == $past(dev_addr);
   endproperty
   a_addr_wait: assert property (p_addr_wait)
      else $error("address changed before status stage");

   property p_addr_commit;
      setup_valid && is_set_addr ##1 (!setup_valid && status_done)
         |=> dev_addr == $past(setup.value_lo[6:0], 2);
   endproperty
   a_addr_commit: assert property (p_addr_commit)
      else $error("new address not adopted");

   property p_cfg_none;
      setup_valid && is_set_cfg && setup.value_lo == `CFG_NONE &&
         dev_state != DEV_DEFAULT |=> dev_state == DEV_ADDRESSED;
   endproperty
   a_cfg_none: assert property (p_cfg_none)
      else $error("configuration 00 did not unconfigure");

   property p_cfg_one;
      setup_valid && is_set_cfg && setup.value_lo == `CFG_ONE &&
         dev_state != DEV_DEFAULT |=> dev_state == DEV_CONFIGURED;
   endproperty
   a_cfg_one: assert property (p_cfg_one)
      else $error("configuration 01 did not configure");

   property p_cfg_bad;
      setup_valid && setup.request == `RQ_SET_CONFIG &&
         setup.value_hi != `ZERO_BYTE |=> req_stall && !req_ack;
   endproperty
   a_cfg_bad: assert property (p_cfg_bad)
      else $error("malformed configuration request accepted");

   property p_state_onehot;
      $onehot(dev_state) && $onehot(ctl);
   endproperty
   a_state_onehot: assert property (p_state_onehot)
      else $error("state code not one-hot");

   c_vendor_read: cover property (reg_rd ##1 in_valid);
   c_addr_done: cover property (ctl == CT_ADDR ##1 dev_state == DEV_ADDRESSED);
   c_configured: cover property (dev_state == DEV_CONFIGURED);
   c_stall: cover property (req_stall);

endmodule

/* File: usb_control_request_decoder_test.sv */
// Self-checking bench for the endpoint zero request decoder.
// Assumes a host model drives setups; register content is a fixed map.
`timescale 1ns/10ps
module usb_control_request_decoder_test
   import usb_ctrl_pkg::*;
;
   logic sys_clk = 1'b0;
   logic rstn;
   logic setup_valid, status_done, req_ack, req_stall, reg_rd, in_valid;
   setup_t setup;
   logic [7:0] reg_rdata, reg_addr, in_data;
   logic [6:0] dev_addr;
   dev_state_t dev_state;
   int miscompares = 0;
   int check_count = 0;
   int cycles = 0;
   always #25 sys_clk = ~sys_clk;
   // The register file answers at once, as the decoder expects.
   assign reg_rdata = reg_addr ^ 8'hA5;
   usb_host_model usb_host_model_inst (.sys_clk(sys_clk),
      .setup_valid(setup_valid), .setup(setup), .status_done(status_done));
   usb_control_request_decoder usb_control_request_decoder_inst (
      .sys_clk(sys_clk), .rstn(rstn), .setup_valid(setup_valid),
      .setup(setup), .status_done(status_done), .reg_rdata(reg_rdata),
      .req_ack(req_ack), .req_stall(req_stall), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .in_valid(in_valid), .in_data(in_data),
      .dev_addr(dev_addr), .dev_state(dev_state));
   ////////////////////////////////////////////////////////////////////
   task automatic chk(input string name, input logic [7:0] seen,
                      input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   function automatic setup_t mk(input logic [7:0] rt, rq, vl, il, ln);
      return {rt, rq, vl, 8'h00, il, 8'h00, ln, 8'h00};
   endfunction
   task automatic req(input setup_t s, input logic ack);
      usb_host_model_inst.send(s);
      #1;
      chk("req_ack", {7'h00, req_ack}, {7'h00, ack});
      chk("req_stall", {7'h00, req_stall}, {7'h00, !ack});
   endtask
   ////////////////////////////////////////////////////////////////////
   task automatic t_read(input logic [7:0] a);
      req(mk(8'hC0, 8'h01, 8'h00, a, 8'h01), 1'b1);
      chk("reg_rd", {7'h00, reg_rd}, 8'h01);
      chk("reg_addr", reg_addr, a);
      @(posedge sys_clk);
      #1;
      chk("in_valid", {7'h00, in_valid}, 8'h01);
      chk("in_data", in_data, a ^ 8'hA5);
   endtask
   task automatic t_bad_read();
      req(mk(8'hC0, 8'h01, 8'h00, 8'h10, 8'h02), 1'b0);
      req(mk(8'hC0, 8'h01, 8'h01, 8'h10, 8'h01), 1'b0);
   endtask
   task automatic t_addr(input logic [7:0] a, input logic ok);
      logic [6:0] old;
      old = dev_addr;
      req(mk(8'h00, 8'h05, a, 8'h00, 8'h00), ok);
      chk("early_addr", {1'b0, dev_addr}, {1'b0, old});
      usb_host_model_inst.finish_status();
      #1;
      chk("dev_addr", {1'b0, dev_addr}, ok ? a : {1'b0, old});
   endtask
   // Status the cycle after the setup, the earliest the host may send it.
   task automatic t_addr_fast(input logic [7:0] a);
      logic [6:0] old;
      old = dev_addr;
      usb_host_model_inst.send(mk(8'h00, 8'h05, a, 8'h00, 8'h00));
      fork
         usb_host_model_inst.status_now();
         begin
            #1;
            chk("fast_ack", {7'h00, req_ack}, 8'h01);
            chk("fast_early", {1'b0, dev_addr}, {1'b0, old});
         end
      join
      #1;
      chk("fast_addr", {1'b0, dev_addr}, a);
   endtask
   task automatic t_cfg();
      req(mk(8'h00, 8'h09, 8'h01, 8'h00, 8'h00), 1'b1);
      chk("cfg1", {5'h00, dev_state}, {5'h00, DEV_CONFIGURED});
      t_read(8'h21);
      req(mk(8'h00, 8'h09, 8'h01, 8'h01, 8'h00), 1'b0);
      req(mk(8'h00, 8'h09, 8'h02, 8'h00, 8'h00), 1'b0);
      req({8'h00, 8'h09, 8'h01, 8'h01, 32'h0000_0000}, 1'b0);
      req(mk(8'h00, 8'h09, 8'h00, 8'h00, 8'h00), 1'b1);
      chk("cfg0", {5'h00, dev_state}, {5'h00, DEV_ADDRESSED});
   endtask
   ////////////////////////////////////////////////////////////////////
   task automatic end_of_test();
      $display("checks %0d miscompares %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // A run of this length needs well under a thousand cycles.
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 3000) begin
         miscompares++;
         end_of_test();
      end
   end
   initial begin
      rstn = 1'b0;
      repeat (20) @(posedge sys_clk);
      rstn <= 1'b1;
      #1;
      chk("rst_addr", {1'b0, dev_addr}, 8'h00);
      chk("rst_state", {5'h00, dev_state}, {5'h00, DEV_DEFAULT});
      t_read(8'h00);
      t_read(8'h3F);
      t_bad_read();
      t_addr(8'h80, 1'b0);
      t_addr(8'h7F, 1'b1);
      chk("addr_st", {5'h00, dev_state}, {5'h00, DEV_ADDRESSED});
      t_addr(8'h25, 1'b1);
      t_addr_fast(8'h33);
      t_cfg();
      t_addr(8'h00, 1'b1);
      chk("unaddr", {5'h00, dev_state}, {5'h00, DEV_DEFAULT});
      end_of_test();
   end
endmodule

/* File: usb_ctrl_map.svh */
// Constants for the endpoint zero control request decoder.
// Assumes setup fields arrive as whole bytes from the serial engine.
`ifndef USB_CTRL_MAP_SVH
`define USB_CTRL_MAP_SVH

`define RT_VENDOR_IN 8'hC0
`define RT_STD_OUT 8'h00
`define RQ_VENDOR_READ 8'h01
`define RQ_SET_ADDRESS 8'h05
`define RQ_SET_CONFIG 8'h09
`define VENDOR_LEN 8'h01
`define ZERO_BYTE 8'h00
`define DEV_ADDR_MAX 8'h7F
`define SENSOR_ADDR_MAX 8'h3F
`define CFG_NONE 8'h00
`define CFG_ONE 8'h01
`define DEV_ADDR_RST 7'h00
`define DATA_RST 8'h00

`endif

/* File: usb_ctrl_pkg.sv */
// Types shared by the control request decoder and its surroundings.
// Assumes the map header is on the include path.
package usb_ctrl_pkg;

   // Eight setup bytes in wire order.
   typedef struct packed {
      logic [7:0] req_type;
      logic [7:0] request;
      logic [7:0] value_lo;
      logic [7:0] value_hi;
      logic [7:0] index_lo;
      logic [7:0] index_hi;
      logic [7:0] length_lo;
      logic [7:0] length_hi;
   } setup_t;

   typedef enum logic [2:0] {
      DEV_DEFAULT = 3'b001,
      DEV_ADDRESSED = 3'b010,
      DEV_CONFIGURED = 3'b100
   } dev_state_t;

   typedef enum logic [2:0] {
      CT_IDLE = 3'b001,
      CT_READ = 3'b010,
      CT_ADDR = 3'b100
   } ctl_state_t;

endpackage

/* File: usb_host_model.sv */
// Host side model: issues setup packets and status stage completions.
// Assumes the decoder samples both on the rising edge of sys_clk.
`timescale 1ns/10ps
module usb_host_model
   import usb_ctrl_pkg::*;
(
   input wire logic sys_clk,
   output logic setup_valid,
   output setup_t setup,
   output logic status_done
);
   initial begin
      setup_valid = 1'b0;
      setup = '0;
      status_done = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////
   // Bytes are inverted after the strobe so stale reads are caught.
   // Callers keep read addresses low and configure only once addressed.
   task automatic send(input setup_t s);
      @(posedge sys_clk);
      setup_valid <= 1'b1;
      setup <= s;
      @(posedge sys_clk);
      setup_valid <= 1'b0;
      setup <= ~s;
   endtask
   // Call in the time step of an edge: the pulse is seen at the next one,
   // the earliest a status stage may follow its setup.
   task automatic status_now();
      status_done <= 1'b1;
      @(posedge sys_clk);
      status_done <= 1'b0;
   endtask
   task automatic finish_status();
      @(posedge sys_clk);
      status_done <= 1'b1;
      @(posedge sys_clk);
      status_done <= 1'b0;
   endtask
endmodule
